// file: clock_stop_cfg.svh
// Purpose: constants for the clock-stop and wake controller
// Assumes: core_clk at 100 MHz
// Notes: offsets are byte addresses on the register bus
`ifndef CLOCK_STOP_CFG_SVH
`define CLOCK_STOP_CFG_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATE 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0c

// control register fields
`define CTRL_SETTLE_LSB 0
`define CTRL_PLL_ON 2
`define CTRL_SIO_EXT 3
`define CTRL_RESET 4'h4

// wake operand bit positions
`define WAKE_PORT0D 0
`define WAKE_TIMER 1
`define WAKE_INTR 3

// event bits of the interrupt status register
`define EV_STOP_ENTER 0
`define EV_WOKE 1
`define EV_STOP_NOP 2
`define EV_W 3

// interrupt sources seen by the wake logic
`define IRQ_SRC_N 8

// timing: clock period and settle tick
`define CLK_NS 10
`define TICK_NS 1000
`define TICK_CYC (`TICK_NS / `CLK_NS)

// oscillator settle times tset in microseconds, one per selection
`define TSET0_US 16'd64
`define TSET1_US 16'd128
`define TSET2_US 16'd256
`define TSET3_US 16'd512

`endif

// file: clock_stop_ctrl.sv
// Purpose: halt and clock-stop control with wake detection
// Assumes: sequencer pulses halt_req or stop_req with wake_operand
// Notes: core_clk is the always-on clock; osc_en gates the crystal
`timescale 1ns/1ps
`default_nettype none
`include "clock_stop_cfg.svh"

//////////////////////////////////////////////////////////////////////
// Functional notes
// - stop instruction turns crystal off, freezes all
// - 4-bit operand bits enable wake conditions
// - wait half tset, then resume next instruction
// - permit and request wake, interrupts on or off
// - any one enabled condition ends stop; here the timer carry ends halt only
// - zero operand: only resets end stop
// - stop acts as nop on CE rise/counter
// - readable flag shows CE reset counter running
// - power-fail detection off during stop
// - stop forces peripheral control registers initial
// - halt keeps peripherals running, CPU suspended
// - stop ceases every peripheral unit
// - program counter held during halt and stop
// - timers, PLL, A/D run halt, stop stop
// - stop turns D/A, FC, serial, beep to ports
// - halt: serial stops as master, runs slave
// - PLL disabled while CE pin low
// - port 0D high input wakes when enabled
module clock_stop_ctrl
    import clock_stop_pkg::*;
(
    input wire logic core_clk, // always-on clock
    input wire logic rst, // power-on reset, async high
    input wire logic hsel, // bus slave select
    input wire logic [31:0] haddr, // bus address
    input wire logic [1:0] htrans, // bus transfer type
    input wire logic hwrite, // bus write
    input wire logic [2:0] hsize, // bus size
    input wire logic [31:0] hwdata, // bus write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // bus read data
    output logic hreadyout, // bus ready out
    output logic hresp, // bus response
    input wire logic halt_req, // halt instruction pulse
    input wire logic stop_req, // stop instruction pulse
    input wire logic [3:0] wake_operand, // wake enables
    input wire logic [`IRQ_SRC_N-1:0] irq_permit, // interrupt permit bits
    input wire logic [`IRQ_SRC_N-1:0] irq_request, // interrupt request flags
    input wire logic timer_carry, // basic timer carry
    input wire logic [3:0] port0d_in, // port 0D levels
    input wire logic ce_pin, // chip enable level
    input wire logic ce_cnt_running, // CE reset counter active
    input wire logic ce_reset, // CE reset pulse
    output logic osc_en, // crystal oscillator on
    output logic cpu_run, // instruction execution on
    output logic pc_hold, // program counter frozen
    output logic resume, // pulse: continue next instr
    output logic stop_nop, // pulse: stop taken as nop
    output logic periph_run, // peripheral clocks on
    output logic periph_init, // pulse: load control defaults
    output logic timer_en, // timers run
    output logic pll_en, // PLL synthesizer on
    output logic adc_en, // A/D converter on
    output logic sio_en, // serial interface shifts
    output logic port_mode, // pins forced to ports
    output logic pfd_en, // power-fail detect on
    output logic irq // interrupt, high level
);

    //////////////////////////////////////////////////////////////////
    pwr_state_e state_r, state_nxt;
    logic [3:0] op_r;
    logic [3:0] ctrl_r;
    logic [`EV_W-1:0] irq_stat_r, irq_mask_r, ev_set;
    logic ce_d_r;
    logic ce_rise, stop_block, int_hit, p0d_hit, wake_stop, wake_halt;
    logic stop_go, settle_done;
    logic ph_wr_r, ph_act_r;
    logic [7:0] ph_addr_r;
    logic acc_ok;

    // wake sources as plain levels; none needs the crystal clock
    assign int_hit = |(irq_permit & irq_request);
    assign p0d_hit = |port0d_in;
    // any single enabled source suffices, the timer for halt only; zero operand never matches
    assign wake_stop = (op_r[`WAKE_INTR] && int_hit)
        || (op_r[`WAKE_PORT0D] && p0d_hit);
    assign wake_halt = wake_stop || (op_r[`WAKE_TIMER] && timer_carry);

    // stop refused on CE rise or while the counter runs
    assign ce_rise = ce_pin && !ce_d_r;
    assign stop_block = ce_rise || ce_cnt_running;
    assign stop_go = stop_req && !stop_block;

    // starts high so a pin already high at reset is not taken as a rise
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ce_d_r <= 1'b1;
        else
            ce_d_r <= ce_pin;
    end

    //////////////////////////////////////////////////////////////////
    settle_timer u_settle
    (
        .core_clk(core_clk),
        .rst(rst),
        .start(state_r == ST_STOP && state_nxt == ST_SETTLE),
        .sel(settle_sel_t'(ctrl_r[`CTRL_SETTLE_LSB +: 2])),
        .done(settle_done)
    );

    // power state sequence
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
            begin
                if (stop_go)
                    state_nxt = ST_STOP;
                else if (halt_req)
                    state_nxt = ST_HALT;
            end
            ST_HALT:
            begin
                if (wake_halt)
                    state_nxt = ST_RUN;
            end
            ST_STOP:
            begin
                if (wake_stop)
                    state_nxt = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                if (settle_done)
                    state_nxt = ST_RUN;
            end
            default: state_nxt = ST_RUN;
        endcase
        // CE reset ends any low-power state
        if (ce_reset)
            state_nxt = ST_RUN;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_r <= ST_RUN;
        else
            state_r <= state_nxt;
    end

    // operand kept for the whole low-power stay
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            op_r <= 4'h0;
        else if (state_r == ST_RUN && (stop_go || halt_req))
            op_r <= wake_operand;
    end

    //////////////////////////////////////////////////////////////////
    // outputs follow the next state so they line up with state_r
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            osc_en <= 1'b1;
            cpu_run <= 1'b1;
            pc_hold <= 1'b0;
            periph_run <= 1'b1;
            timer_en <= 1'b1;
            adc_en <= 1'b1;
            port_mode <= 1'b0;
            pfd_en <= 1'b1;
        end
        else
        begin
            // oscillator back on as soon as wake is seen, before settling
            osc_en <= (state_nxt != ST_STOP);
            cpu_run <= (state_nxt == ST_RUN);
            pc_hold <= (state_nxt != ST_RUN);
            periph_run <= (state_nxt == ST_RUN || state_nxt == ST_HALT);
            timer_en <= (state_nxt == ST_RUN || state_nxt == ST_HALT);
            adc_en <= (state_nxt == ST_RUN || state_nxt == ST_HALT);
            port_mode <= (state_nxt == ST_STOP);
            pfd_en <= (state_nxt != ST_STOP);
        end
    end

    // PLL and serial interface depend on more than the state
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pll_en <= 1'b0;
            sio_en <= 1'b1;
        end
        else
        begin
            pll_en <= ctrl_r[`CTRL_PLL_ON] && ce_pin
                && (state_nxt == ST_RUN || state_nxt == ST_HALT);
            sio_en <= (state_nxt == ST_RUN)
                || (state_nxt == ST_HALT && ctrl_r[`CTRL_SIO_EXT]);
        end
    end

    // one-cycle event pulses to the sequencer
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            resume <= 1'b0;
            stop_nop <= 1'b0;
            periph_init <= 1'b0;
        end
        else
        begin
            resume <= (state_r != ST_RUN) && (state_nxt == ST_RUN);
            stop_nop <= (state_r == ST_RUN) && stop_req && stop_block;
            periph_init <= (state_r == ST_RUN) && stop_go;
        end
    end

    //////////////////////////////////////////////////////////////////
    // bus slave, zero wait states, always OKAY
    assign acc_ok = hsel && hready && htrans[1];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ph_act_r <= 1'b0;
            ph_wr_r <= 1'b0;
            ph_addr_r <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (hready)
        begin
            ph_act_r <= acc_ok;
            ph_wr_r <= hwrite;
            ph_addr_r <= haddr[7:0];
        end
    end

    // read data prepared in the address phase; unmapped reads as zero
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (acc_ok && !hwrite)
        begin
            case (haddr[7:0])
                `OFS_CTRL: hrdata <= {28'h0, ctrl_r};
                `OFS_STATE: hrdata <= {23'h0, ce_cnt_running, op_r, 2'h0,
                    state_r};
                `OFS_IRQ_STAT: hrdata <= {29'h0, irq_stat_r};
                `OFS_IRQ_MASK: hrdata <= {29'h0, irq_mask_r};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // control register; stop loads defaults, like the peripherals
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ctrl_r <= `CTRL_RESET;
        else if (state_r == ST_RUN && stop_go)
            ctrl_r <= `CTRL_RESET;
        else if (ph_act_r && ph_wr_r && ph_addr_r == `OFS_CTRL)
            ctrl_r <= hwdata[3:0];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            irq_mask_r <= '0;
        else if (ph_act_r && ph_wr_r && ph_addr_r == `OFS_IRQ_MASK)
            irq_mask_r <= hwdata[`EV_W-1:0];
    end

    // sticky events, write one to clear; a new event beats the clear
    always_comb
    begin
        ev_set = '0;
        ev_set[`EV_STOP_ENTER] = (state_r == ST_RUN) && stop_go;
        ev_set[`EV_WOKE] = (state_r == ST_SETTLE) && (state_nxt == ST_RUN);
        ev_set[`EV_STOP_NOP] = (state_r == ST_RUN) && stop_req && stop_block;
    end

    generate
        for (genvar i = 0; i < `EV_W; i++)
        begin : g_ev
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    irq_stat_r[i] <= 1'b0;
                else if (ev_set[i])
                    irq_stat_r[i] <= 1'b1;
                else if (ph_act_r && ph_wr_r && ph_addr_r == `OFS_IRQ_STAT && hwdata[i])
                    irq_stat_r[i] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_r & irq_mask_r);
    end

    //////////////////////////////////////////////////////////////////
    sequence stop_taken_s;
        state_r == ST_RUN && stop_req && !stop_block;
    endsequence

    sequence stop_held_s;
        state_r == ST_STOP && !osc_en && !periph_run;
    endsequence

    stop_enter_a: assert property (@(posedge core_clk) disable iff (rst)
        stop_taken_s |=> stop_held_s and periph_init)
        else $error("stop not entered with oscillator off");

    stop_nop_a: assert property (@(posedge core_clk) disable iff (rst)
        state_r == ST_RUN && stop_req && stop_block |=> state_r != ST_STOP && stop_nop)
        else $error("blocked stop did not act as nop");

    int_wake_a: assert property (@(posedge core_clk) disable iff (rst)
        state_r == ST_STOP && op_r[`WAKE_INTR] && int_hit && !ce_reset
        |=> state_r == ST_SETTLE && osc_en)
        else $error("interrupt wake missed");

    p0d_wake_a: assert property (@(posedge core_clk) disable iff (rst)
        state_r == ST_STOP && op_r[`WAKE_PORT0D] && p0d_hit && !ce_reset
        |=> state_r == ST_SETTLE)
        else $error("port 0D wake missed");

    zero_op_a: assert property (@(posedge core_clk) disable iff (rst)
        state_r == ST_STOP && op_r == 4'h0 && !ce_reset |=> state_r == ST_STOP)
        else $error("stop left with zero operand");

    settle_end_a: assert property (@(posedge core_clk) disable iff (rst)
        state_r == ST_SETTLE && !settle_done && !ce_reset |=> state_r == ST_SETTLE
        and !cpu_run)
        else $error("settle cut short");

    stop_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
        stop_held_s |-> !pfd_en && !timer_en && !pll_en && !adc_en && port_mode)
        else $error("activity during stop");

    halt_run_a: assert property (@(posedge core_clk) disable iff (rst)
        state_r == ST_HALT |-> periph_run && !cpu_run && pc_hold)
        else $error("halt state outputs wrong");

    ce_pll_a: assert property (@(posedge core_clk) disable iff (rst)
        !ce_pin |=> !pll_en)
        else $error("PLL on with CE low");

    sio_halt_a: assert property (@(posedge core_clk) disable iff (rst)
        state_r == ST_HALT |-> sio_en == $past(ctrl_r[`CTRL_SIO_EXT]))
        else $error("serial halt mode wrong");

    ce_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        acc_ok && !hwrite && haddr[7:0] == `OFS_STATE
        |=> hrdata[8] == $past(ce_cnt_running))
        else $error("CE counter flag not shown");

endmodule
`default_nettype wire

// file: clock_stop_pkg.sv
// Purpose: shared types of the clock-stop and wake controller
// Assumes: nothing beyond the cfg header
// Notes: numbers live in clock_stop_cfg.svh
`default_nettype none
package clock_stop_pkg;

    // power state of the core
    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STOP, ST_SETTLE} pwr_state_e;

    typedef logic [1:0] settle_sel_t;

endpackage
`default_nettype wire

// file: cpu_seq_model.sv
// Purpose: instruction sequencer and interrupt logic facing the stop controller
// Assumes: requests launched right after a rising edge, one-cycle pulses
// Notes: operand shows the inverse of the last value once released
`timescale 1ns/1ps
`default_nettype none
`include "clock_stop_cfg.svh"

module cpu_seq_model (
    input wire logic core_clk, // system clock
    output logic halt_req, // halt instruction pulse
    output logic stop_req, // stop instruction pulse
    output logic [3:0] wake_operand, // wake enables
    output logic [`IRQ_SRC_N-1:0] irq_permit, // permit bits
    output logic [`IRQ_SRC_N-1:0] irq_request // request flags
);
    // idle sequencer at time zero
    initial
    begin
        halt_req = 1'b0;
        stop_req = 1'b0;
        wake_operand = 4'h0;
        irq_permit = '0;
        irq_request = '0;
    end

    //////////////////////////////////////////////////////////////////////
    // one instruction, operand valid only with its pulse
    task automatic issue(input logic is_stop, input logic [3:0] op);
        @(posedge core_clk);
        stop_req <= is_stop;
        halt_req <= ~is_stop;
        wake_operand <= op;
        @(posedge core_clk);
        stop_req <= 1'b0;
        halt_req <= 1'b0;
        wake_operand <= ~op; // released, so no stale value lingers
    endtask

    // per-source permit and request levels
    task automatic set_irq(input logic [`IRQ_SRC_N-1:0] p, input logic [`IRQ_SRC_N-1:0] r);
        @(posedge core_clk);
        irq_permit <= p;
        irq_request <= r;
    endtask
endmodule
`default_nettype wire

// file: settle_timer.sv
// Purpose: counts half the oscillator settle time after a stop wake
// Assumes: start is a one-cycle pulse
// Notes: counts 1 us ticks from a prescaler
`timescale 1ns/1ps
`default_nettype none
`include "clock_stop_cfg.svh"

module settle_timer
    import clock_stop_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic start, // begin a settle wait
    input wire clock_stop_pkg::settle_sel_t sel, // settle time choice
    output logic done // one-cycle pulse at end
);

    logic [7:0] pre_r;
    logic [15:0] cnt_r;
    logic busy_r;
    logic tick;

    // half of the selected tset, in microsecond ticks
    function automatic logic [15:0] half_tset(input settle_sel_t s);
        case (s)
            2'h0: half_tset = `TSET0_US >> 1;
            2'h1: half_tset = `TSET1_US >> 1;
            2'h2: half_tset = `TSET2_US >> 1;
            default: half_tset = `TSET3_US >> 1;
        endcase
    endfunction

    assign tick = (pre_r == 8'(`TICK_CYC - 1));

    // prescaler restarts with each wait so the first tick is a full one
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pre_r <= 8'h00;
        else if (start || tick || !busy_r)
            pre_r <= 8'h00;
        else
            pre_r <= pre_r + 8'h01;
    end

    // down counter of ticks
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= 16'h0000;
            busy_r <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                cnt_r <= half_tset(sel);
                busy_r <= 1'b1;
            end
            else if (busy_r && tick)
            begin
                if (cnt_r <= 16'h0001)
                begin
                    busy_r <= 1'b0;
                    done <= 1'b1;
                end
                cnt_r <= cnt_r - 16'h0001;
            end
        end
    end

endmodule
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench for the clock-stop and wake controller
// Assumes: one clock, inputs driven by non-blocking assignment at the edge
// Notes: settle wait uses the reset selection, reloaded by every accepted stop
`timescale 1ns/1ps
`default_nettype none
`include "clock_stop_cfg.svh"

module tb;
    import clock_stop_pkg::*;
    localparam int half_cyc = (`TSET0_US / 2) * `TICK_CYC;
    logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, halt_req, stop_req, timer_carry = 1'b0;
    logic [3:0] wake_operand, port0d_in = 4'h0;
    logic [`IRQ_SRC_N-1:0] irq_permit, irq_request;
    logic ce_pin = 1'b1, ce_cnt_running = 1'b0, ce_reset = 1'b0;
    logic osc_en, cpu_run, pc_hold, resume, stop_nop, periph_run, periph_init;
    logic timer_en, pll_en, adc_en, sio_en, port_mode, pfd_en, irq;
    int n_errors = 0, n_checks = 0;

    // clock and the single-slave ready loop
    always #5 core_clk = ~core_clk;
    assign hready = hreadyout;

    cpu_seq_model u_cpu (.core_clk(core_clk), .halt_req(halt_req), .stop_req(stop_req),
        .wake_operand(wake_operand), .irq_permit(irq_permit), .irq_request(irq_request));

    clock_stop_ctrl u_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_req(halt_req),
        .stop_req(stop_req), .wake_operand(wake_operand), .irq_permit(irq_permit),
        .irq_request(irq_request), .timer_carry(timer_carry), .port0d_in(port0d_in),
        .ce_pin(ce_pin), .ce_cnt_running(ce_cnt_running), .ce_reset(ce_reset),
        .osc_en(osc_en), .cpu_run(cpu_run), .pc_hold(pc_hold), .resume(resume),
        .stop_nop(stop_nop), .periph_run(periph_run), .periph_init(periph_init),
        .timer_en(timer_en), .pll_en(pll_en), .adc_en(adc_en), .sio_en(sio_en),
        .port_mode(port_mode), .pfd_en(pfd_en), .irq(irq));

    //////////////////////////////////////////////////////////////////////
    // verdict in one place only
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    // one edge, then let its updates land
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask

    // single transfer: address phase held until ready, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // wait for resume under a bound, return cycles taken
    task automatic wait_resume(output int n);
        for (n = 0; n < 4000 && resume !== 1'b1; n++)
            step;
    endtask

    //////////////////////////////////////////////////////////////////////
    // reset values and register map
    task automatic t_reset;
        check("osc", 1, osc_en);
        check("run", 1, cpu_run);
        check("pfd", 1, pfd_en);
        check("pll", 1, pll_en);
        ahb(1'b0, `OFS_CTRL, 0);
        check("ctrl", 32'h4, rd);
        ahb(1'b0, `OFS_IRQ_MASK, 0);
        check("mask", 0, rd);
        ahb(1'b0, 8'h10, 0);
        check("unmapped", 0, rd);
        check("resp", 0, hresp);
        check("ready", 1, hreadyout);
    endtask

    // stop woken by permitted interrupt, settle timed
    task automatic t_stop_irq;
        int n;
        ahb(1'b1, `OFS_CTRL, 32'h3);
        u_cpu.issue(1'b1, 4'b1000);
        #1;
        check("osc", 0, osc_en);
        check("init", 1, periph_init);
        check("periph", 0, periph_run);
        check("tmr", 0, timer_en);
        check("pll", 0, pll_en);
        check("adc", 0, adc_en);
        check("ports", 1, port_mode);
        check("pfd", 0, pfd_en);
        check("pc", 1, pc_hold);
        u_cpu.set_irq(8'h01, 8'h00);
        repeat (20) step;
        check("osc", 0, osc_en);
        u_cpu.set_irq(8'h01, 8'h01);
        for (n = 0; n < 5 && osc_en !== 1'b1; n++) step;
        check("osc", 1, osc_en);
        check("run", 0, cpu_run);
        wait_resume(n);
        check("settle", 1, (n >= half_cyc - 1 && n <= half_cyc + 3));
        u_cpu.set_irq(8'h00, 8'h00);
        step;
        check("run", 1, cpu_run);
        ahb(1'b0, `OFS_CTRL, 0);
        check("ctrl", 32'h4, rd);
    endtask

    // two enables, port level alone wakes
    task automatic t_stop_port;
        int n;
        u_cpu.issue(1'b1, 4'b1001);
        port0d_in <= 4'h2;
        wait_resume(n);
        check("resume", 1, resume);
        @(posedge core_clk);
        port0d_in <= 4'h0;
    endtask

    // zero operand ignores all wakes until reset
    task automatic t_stop_zero;
        int n;
        u_cpu.issue(1'b1, 4'b0000);
        port0d_in <= 4'hf;
        u_cpu.set_irq(8'hff, 8'hff);
        repeat (30) step;
        check("osc", 0, osc_en);
        @(posedge core_clk);
        ce_reset <= 1'b1;
        @(posedge core_clk);
        ce_reset <= 1'b0;
        port0d_in <= 4'h0;
        u_cpu.set_irq(8'h00, 8'h00);
        for (n = 0; n < 3 && cpu_run !== 1'b1; n++) step;
        check("run", 1, cpu_run);
    endtask

    // stop refused while counter runs or on CE rise
    task automatic t_stop_nop;
        @(posedge core_clk);
        ce_cnt_running <= 1'b1;
        ahb(1'b0, `OFS_STATE, 0);
        check("state", 32'h100, rd);
        u_cpu.issue(1'b1, 4'b1000);
        #1;
        check("nop", 1, stop_nop);
        check("osc", 1, osc_en);
        @(posedge core_clk);
        ce_cnt_running <= 1'b0;
        ce_pin <= 1'b0;
        repeat (2) step;
        check("pll", 0, pll_en);
        fork
            u_cpu.issue(1'b1, 4'b1000);
            begin
                @(posedge core_clk);
                ce_pin <= 1'b1;
            end
        join
        #1;
        check("nop", 1, stop_nop);
        check("osc", 1, osc_en);
    endtask

    // halt keeps peripherals, serial follows clock source
    task automatic t_halt;
        int n;
        u_cpu.issue(1'b0, 4'b0010);
        #1;
        check("run", 0, cpu_run);
        check("pc", 1, pc_hold);
        check("periph", 1, periph_run);
        check("tmr", 1, timer_en);
        check("adc", 1, adc_en);
        check("pll", 1, pll_en);
        check("sio", 0, sio_en);
        @(posedge core_clk);
        timer_carry <= 1'b1;
        wait_resume(n);
        check("resume", 1, resume);
        @(posedge core_clk);
        timer_carry <= 1'b0;
        ahb(1'b1, `OFS_CTRL, 32'hc);
        u_cpu.issue(1'b0, 4'b1000);
        #1;
        check("sio", 1, sio_en);
        u_cpu.set_irq(8'h80, 8'h80);
        wait_resume(n);
        check("resume", 1, resume);
        u_cpu.set_irq(8'h00, 8'h00);
    endtask

    // sticky events, mask and write-one clear
    task automatic t_irq;
        ahb(1'b0, `OFS_IRQ_STAT, 0);
        check("stat", 32'h7, rd);
        check("irq", 0, irq);
        ahb(1'b1, `OFS_IRQ_MASK, 32'h2);
        repeat (2) step;
        check("irq", 1, irq);
        ahb(1'b1, `OFS_IRQ_STAT, 32'h2);
        ahb(1'b0, `OFS_IRQ_STAT, 0);
        check("stat", 32'h5, rd);
        check("irq", 0, irq);
    endtask

    //////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        step;
        t_reset();
        t_stop_irq();
        t_stop_port();
        t_stop_zero();
        t_stop_nop();
        t_halt();
        t_irq();
        finish_test();
    end

    // watchdog, well beyond the two settle waits
    initial
    begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
